// ### hdl/usart_pkg.sv
// constants shared by the serial transceiver: register map, field layout,
// reset values and frame encodings
// assumes a 32-bit AXI4-Lite master and a 50 MHz peripheral clock
package usart_pkg;
  // register byte addresses
  localparam logic [7:0] TX_LOW_OFS = 8'h00;
  localparam logic [7:0] TX_HIGH_OFS = 8'h04;
  localparam logic [7:0] RX_LOW_OFS = 8'h08;
  localparam logic [7:0] RX_HIGH_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] CTRL_OFS = 8'h14;
  localparam logic [7:0] FRAME_OFS = 8'h18;
  localparam logic [7:0] BAUD_OFS = 8'h1c;
  // status and high receive byte fields
  localparam int STAT_RXC = 7;
  localparam int STAT_TXC = 6;
  localparam int STAT_DRE = 5;
  localparam int RXH_RXC = 7;
  localparam int RXH_OVF = 6;
  localparam int RXH_FE = 2;
  localparam int RXH_PE = 1;
  // control fields
  localparam int CTRL_RXEN = 7;
  localparam int CTRL_TXEN = 6;
  localparam int CTRL_XCKHOST = 2;
  localparam int CTRL_DBL = 1;
  // frame configuration fields
  localparam int FRAME_SYNC = 6;
  localparam int FRAME_PAR_HI = 5;
  localparam int FRAME_PAR_LO = 4;
  localparam int FRAME_STOP2 = 3;
  localparam logic [2:0] CS_9L = 3'h6;
  localparam logic [2:0] CS_9H = 3'h7;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FRAME_RST = 8'h03;
  localparam logic [15:0] BAUD_RST = 16'h0040;
  // samples per bit, baud accumulator steps and axi4-lite response codes
  localparam logic [4:0] SPB_NORMAL = 5'h10;
  localparam logic [4:0] SPB_DOUBLE = 5'h08;
  localparam logic [4:0] SPB_SYNC = 5'h02;
  localparam logic [16:0] ACC_INC_ASYNC = 17'h00040;
  localparam logic [16:0] ACC_INC_SYNC = 17'h00001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [3:0] char_bits(input logic [2:0] cs);
    case (cs)
      3'h0: char_bits = 4'h5;
      3'h1: char_bits = 4'h6;
      3'h2: char_bits = 4'h7;
      CS_9L, CS_9H: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction
endpackage

// ### hdl/usart_frame_baud_txrx.sv
// serial transceiver core: fractional baud generator, transmit path with
// data register and buffer, double-buffered receiver with error flags
// assumes an AXI4-Lite master with one write and one read outstanding,
// and pins synchronous to clock_in
//
// Notes on behaviour
// - frame is low start, data bits, optional parity, then high stop bits.
// - five to nine data bits, none/even/odd parity, one or two stops.
// - next start may follow stop at once; otherwise line idles high.
// - bit clock is the internal baud generator or the transfer clock pin.
// - baud divisor is factor times 64; rate 64*fclk/(S*divisor).
// - synchronous rate uses only divisor bits 15:6; fraction written zero.
// - sixteen samples per bit normal, eight double speed, two synchronous.
// - written data goes to buffer when empty, then to the shifter.
// - transmit complete flag set when shifter done and nothing pending.
// - empty flag shows data register free; software writes only then.
// - unused upper bits of short characters are ignored on transmit.
// - transmitter disable waits until all pending data has been sent.
// - disabled transmitter releases the pin, which becomes an input.
// - receiver starts on valid start bit, ignores the second stop bit.
// - first stop bit pushes frame into buffer and sets receive complete.
// - two-entry buffer shows the oldest frame at the read registers.
// - advancing byte depends on nine-bit order; other byte read first.
// - frame, overflow and parity flags travel with their frame.
// - overflow marks the frame after which a new frame was lost.
// - parity error when computed parity disagrees with received bit.
// - receiver disable is immediate, flushing buffer and reception.
`timescale 1ns/1ps
`default_nettype none
module usart_frame_baud_txrx (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // axi4-lite write
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [7:0] axi_awaddr_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  output logic [1:0] axi_bresp_out,
  // axi4-lite read
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  input wire logic [7:0] axi_araddr_in,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  // serial pins
  input wire logic rxd_in,
  output logic txd_out,
  output logic txd_oe_n_out,
  input wire logic transfer_clock_pin_in,
  output logic transfer_clock_pin_out,
  output logic transfer_clock_pin_oe_n_out
);
  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [7:0] cfg;
    logic [15:0] baud;
    logic [16:0] acc;
    logic clk_drv;
    logic clk_oe_n;
    logic clk_prev;
    logic tx_en;
    logic [8:0] dr;
    logic dr_full;
    logic [8:0] tb;
    logic tb_full;
    logic tx_busy;
    logic [3:0] tx_idx;
    logic [4:0] tx_cnt;
    logic [8:0] tx_sh;
    logic txd;
    logic txd_oe_n;
    logic tx_done;
    logic rx_busy;
    logic rx_first;
    logic [4:0] rx_cnt;
    logic [3:0] rx_idx;
    logic [8:0] rx_sh;
    logic rx_par;
    logic [1:0][8:0] rb_data;
    logic [1:0] rb_fe;
    logic [1:0] rb_pe;
    logic [1:0] rb_ov;
    logic [1:0] rb_cnt;
  } state_type;

  state_type s_r;
  state_type s_nxt;
  logic tick;
  logic clk_rise;
  logic clk_fall;
  logic sync_mode;
  logic par_en;
  logic par_odd;
  logic [3:0] nbits;
  logic [3:0] tx_last;
  logic [4:0] spb;
  logic [4:0] rx_target;
  logic [8:0] mask;
  logic [16:0] acc_sum;
  logic [16:0] div;
  logic tx_ev;
  logic tx_finish;
  logic rx_ev;
  logic push;
  logic pop;
  logic [7:0] radv;
  logic [2:0] cs;

  always_comb begin
    s_nxt = s_r;
    cs = s_r.cfg[2:0];
    nbits = usart_pkg::char_bits(cs);
    mask = 9'h1ff >> (4'h9 - nbits);
    sync_mode = s_r.cfg[usart_pkg::FRAME_SYNC];
    par_en = s_r.cfg[usart_pkg::FRAME_PAR_HI];
    par_odd = s_r.cfg[usart_pkg::FRAME_PAR_LO];
    tx_last = nbits + {3'h0, par_en}
      + (s_r.cfg[usart_pkg::FRAME_STOP2] ? 4'h2 : 4'h1);
    spb = sync_mode ? usart_pkg::SPB_SYNC :
      (s_r.ctrl[usart_pkg::CTRL_DBL] ? usart_pkg::SPB_DOUBLE :
      usart_pkg::SPB_NORMAL);
    rx_target = s_r.rx_first ? (spb >> 1) - 5'h01 : spb - 5'h01;
    radv = (cs == usart_pkg::CS_9L) ? usart_pkg::RX_HIGH_OFS :
      usart_pkg::RX_LOW_OFS;
    tx_finish = 1'b0;
    push = 1'b0;
    pop = 1'b0;

    // fractional baud generator: add 64 per clock (1 when synchronous), tick on wrap
    div = sync_mode ? {7'h00, s_r.baud[15:6]} : {1'b0, s_r.baud};
    acc_sum = s_r.acc + (sync_mode ? usart_pkg::ACC_INC_SYNC :
      usart_pkg::ACC_INC_ASYNC);
    tick = 1'b0;
    if (acc_sum >= div) begin
      tick = 1'b1;
      s_nxt.acc = acc_sum - div;
    end else begin
      s_nxt.acc = acc_sum;
    end

    // transfer clock: driven in synchronous host, sampled in client
    s_nxt.clk_prev = transfer_clock_pin_in;
    clk_rise = 1'b0;
    clk_fall = 1'b0;
    s_nxt.clk_oe_n = 1'b1;
    if (sync_mode && s_r.ctrl[usart_pkg::CTRL_XCKHOST]) begin
      s_nxt.clk_oe_n = 1'b0;
      if (tick) begin
        s_nxt.clk_drv = !s_r.clk_drv;
        clk_rise = !s_r.clk_drv;
        clk_fall = s_r.clk_drv;
      end
    end else if (sync_mode) begin
      clk_rise = transfer_clock_pin_in && !s_r.clk_prev;
      clk_fall = !transfer_clock_pin_in && s_r.clk_prev;
    end
    tx_ev = sync_mode ? clk_rise : (tick && s_r.tx_cnt == spb - 5'h01);
    rx_ev = sync_mode ? clk_fall :
      (tick && s_r.rx_busy && s_r.rx_cnt == rx_target);
    if (tick) begin
      s_nxt.tx_cnt = (s_r.tx_cnt == spb - 5'h01) ? 5'h00 :
        s_r.tx_cnt + 5'h01;
      s_nxt.rx_cnt = (s_r.rx_cnt == rx_target) ? 5'h00 :
        s_r.rx_cnt + 5'h01;
    end

    // axi4-lite read
    if (s_r.rvalid && axi_rready_in) begin
      s_nxt.rvalid = 1'b0;
    end
    if (axi_arvalid_in && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = usart_pkg::RESP_OKAY;
      s_nxt.rdata = 32'h0;
      if (axi_araddr_in == usart_pkg::RX_LOW_OFS) begin
        s_nxt.rdata[7:0] = s_r.rb_data[0][7:0];
      end else if (axi_araddr_in == usart_pkg::RX_HIGH_OFS) begin
        s_nxt.rdata[usart_pkg::RXH_RXC] = s_r.rb_cnt != 2'h0;
        s_nxt.rdata[usart_pkg::RXH_OVF] = s_r.rb_ov[0];
        s_nxt.rdata[usart_pkg::RXH_FE] = s_r.rb_fe[0];
        s_nxt.rdata[usart_pkg::RXH_PE] = s_r.rb_pe[0];
        s_nxt.rdata[0] = s_r.rb_data[0][8];
      end else if (axi_araddr_in == usart_pkg::STATUS_OFS) begin
        s_nxt.rdata[usart_pkg::STAT_RXC] = s_r.rb_cnt != 2'h0;
        s_nxt.rdata[usart_pkg::STAT_TXC] = s_r.tx_done;
        s_nxt.rdata[usart_pkg::STAT_DRE] = !s_r.dr_full;
      end else if (axi_araddr_in == usart_pkg::CTRL_OFS) begin
        s_nxt.rdata[7:0] = s_r.ctrl;
      end else if (axi_araddr_in == usart_pkg::FRAME_OFS) begin
        s_nxt.rdata[7:0] = s_r.cfg;
      end else if (axi_araddr_in == usart_pkg::BAUD_OFS) begin
        s_nxt.rdata[15:0] = s_r.baud;
      end else if (axi_araddr_in != usart_pkg::TX_LOW_OFS &&
          axi_araddr_in != usart_pkg::TX_HIGH_OFS) begin
        s_nxt.rresp = usart_pkg::RESP_SLVERR;
      end
      pop = axi_araddr_in == radv && s_r.rb_cnt != 2'h0;
    end
    s_nxt.arready = !s_nxt.rvalid;

    // axi4-lite write: address and data taken in either order
    if (s_r.bvalid && axi_bready_in) begin
      s_nxt.bvalid = 1'b0;
    end
    if (axi_awvalid_in && s_r.awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr = axi_awaddr_in;
    end
    if (axi_wvalid_in && s_r.wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata = axi_wdata_in;
      s_nxt.wstrb = axi_wstrb_in;
    end
    if (s_nxt.aw_held && s_nxt.w_held && !s_r.bvalid) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = usart_pkg::RESP_OKAY;
      if (s_nxt.awaddr == usart_pkg::TX_LOW_OFS) begin
        if (s_nxt.wstrb[0] && !s_r.dr_full) begin
          s_nxt.dr[7:0] = s_nxt.wdata[7:0];
          if (cs == usart_pkg::CS_9H) begin
            s_nxt.dr_full = 1'b1;
          end else if (cs != usart_pkg::CS_9L) begin
            s_nxt.dr[8] = 1'b0;
            s_nxt.dr_full = 1'b1;
          end
        end
      end else if (s_nxt.awaddr == usart_pkg::TX_HIGH_OFS) begin
        if (s_nxt.wstrb[0] && !s_r.dr_full) begin
          s_nxt.dr[8] = s_nxt.wdata[0];
          s_nxt.dr_full = cs == usart_pkg::CS_9L;
        end
      end else if (s_nxt.awaddr == usart_pkg::STATUS_OFS) begin
        if (s_nxt.wstrb[0] && s_nxt.wdata[usart_pkg::STAT_TXC]) begin
          s_nxt.tx_done = 1'b0;
        end
      end else if (s_nxt.awaddr == usart_pkg::CTRL_OFS) begin
        if (s_nxt.wstrb[0]) begin
          s_nxt.ctrl = s_nxt.wdata[7:0];
        end
      end else if (s_nxt.awaddr == usart_pkg::FRAME_OFS) begin
        if (s_nxt.wstrb[0]) begin
          s_nxt.cfg = s_nxt.wdata[7:0];
        end
      end else if (s_nxt.awaddr == usart_pkg::BAUD_OFS) begin
        if (s_nxt.wstrb[0]) begin
          s_nxt.baud[7:0] = s_nxt.wdata[7:0];
        end
        if (s_nxt.wstrb[1]) begin
          s_nxt.baud[15:8] = s_nxt.wdata[15:8];
        end
      end else if (s_nxt.awaddr != usart_pkg::RX_LOW_OFS &&
          s_nxt.awaddr != usart_pkg::RX_HIGH_OFS) begin
        s_nxt.bresp = usart_pkg::RESP_SLVERR;
      end
    end
    s_nxt.awready = !s_nxt.aw_held;
    s_nxt.wready = !s_nxt.w_held;

    // transmit shifter
    if (s_r.tx_busy && tx_ev) begin
      if (s_r.tx_idx == tx_last) begin
        s_nxt.tx_busy = 1'b0;
        tx_finish = 1'b1;
      end else begin
        s_nxt.tx_idx = s_r.tx_idx + 4'h1;
      end
    end
    if (tx_finish && !s_r.dr_full && !s_r.tb_full) begin
      s_nxt.tx_done = 1'b1;
    end
    if (!s_nxt.tx_busy && s_r.tb_full && s_r.tx_en &&
        (!sync_mode || clk_rise)) begin
      s_nxt.tx_sh = s_r.tb & mask;
      s_nxt.tb_full = 1'b0;
      s_nxt.tx_busy = 1'b1;
      s_nxt.tx_idx = 4'h0;
      s_nxt.tx_cnt = 5'h00;
    end
    if (s_r.dr_full && !s_nxt.tb_full) begin
      s_nxt.tb = s_r.dr;
      s_nxt.tb_full = 1'b1;
      s_nxt.dr_full = 1'b0;
    end
    if (!s_nxt.tx_busy) begin
      s_nxt.txd = 1'b1;
    end else if (s_nxt.tx_idx == 4'h0) begin
      s_nxt.txd = 1'b0;
    end else if (s_nxt.tx_idx <= nbits) begin
      s_nxt.txd = s_nxt.tx_sh[s_nxt.tx_idx - 4'h1];
    end else if (par_en && s_nxt.tx_idx == nbits + 4'h1) begin
      s_nxt.txd = (^s_nxt.tx_sh) ^ par_odd;
    end else begin
      s_nxt.txd = 1'b1;
    end
    if (s_nxt.ctrl[usart_pkg::CTRL_TXEN]) begin
      s_nxt.tx_en = 1'b1;
    end else if (!s_nxt.tx_busy && !s_nxt.tb_full && !s_nxt.dr_full) begin
      s_nxt.tx_en = 1'b0;
    end
    s_nxt.txd_oe_n = !s_nxt.tx_en;

    // receive buffer pop
    if (pop) begin
      s_nxt.rb_data[0] = s_r.rb_data[1];
      s_nxt.rb_fe[0] = s_r.rb_fe[1];
      s_nxt.rb_pe[0] = s_r.rb_pe[1];
      s_nxt.rb_ov[0] = s_r.rb_ov[1];
      s_nxt.rb_ov[1] = 1'b0;
      s_nxt.rb_cnt = s_r.rb_cnt - 2'h1;
    end

    // receiver
    if (!s_r.rx_busy && s_r.ctrl[usart_pkg::CTRL_RXEN] && !rxd_in &&
        (sync_mode ? clk_fall : tick)) begin
      s_nxt.rx_busy = 1'b1;
      s_nxt.rx_first = !sync_mode;
      s_nxt.rx_cnt = 5'h00;
      s_nxt.rx_idx = 4'h0;
      s_nxt.rx_sh = 9'h000;
    end else if (s_r.rx_busy && rx_ev) begin
      if (s_r.rx_first) begin
        s_nxt.rx_first = 1'b0;
        s_nxt.rx_busy = !rxd_in;
      end else if (s_r.rx_idx < nbits) begin
        s_nxt.rx_sh[s_r.rx_idx] = rxd_in;
        s_nxt.rx_idx = s_r.rx_idx + 4'h1;
      end else if (par_en && s_r.rx_idx == nbits) begin
        s_nxt.rx_par = rxd_in;
        s_nxt.rx_idx = s_r.rx_idx + 4'h1;
      end else begin
        push = 1'b1;
        s_nxt.rx_busy = 1'b0;
      end
    end
    if (push) begin
      if (s_nxt.rb_cnt == 2'h2) begin
        s_nxt.rb_ov[1] = 1'b1;
      end else begin
        s_nxt.rb_data[s_nxt.rb_cnt[0]] = s_r.rx_sh;
        s_nxt.rb_fe[s_nxt.rb_cnt[0]] = !rxd_in;
        s_nxt.rb_pe[s_nxt.rb_cnt[0]] = par_en &&
          ((^s_r.rx_sh ^ s_r.rx_par) != par_odd);
        s_nxt.rb_ov[s_nxt.rb_cnt[0]] = 1'b0;
        s_nxt.rb_cnt = s_nxt.rb_cnt + 2'h1;
      end
    end
    if (!s_nxt.ctrl[usart_pkg::CTRL_RXEN]) begin
      s_nxt.rx_busy = 1'b0;
      s_nxt.rb_cnt = 2'h0;
      s_nxt.rb_ov = 2'h0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
      s_r.ctrl <= usart_pkg::CTRL_RST;
      s_r.cfg <= usart_pkg::FRAME_RST;
      s_r.baud <= usart_pkg::BAUD_RST;
      s_r.txd <= 1'b1;
      s_r.txd_oe_n <= 1'b1;
      s_r.clk_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign axi_awready_out = s_r.awready;
  assign axi_wready_out = s_r.wready;
  assign axi_bvalid_out = s_r.bvalid;
  assign axi_bresp_out = s_r.bresp;
  assign axi_arready_out = s_r.arready;
  assign axi_rvalid_out = s_r.rvalid;
  assign axi_rdata_out = s_r.rdata;
  assign axi_rresp_out = s_r.rresp;
  assign txd_out = s_r.txd;
  assign txd_oe_n_out = s_r.txd_oe_n;
  assign transfer_clock_pin_out = s_r.clk_drv;
  assign transfer_clock_pin_oe_n_out = s_r.clk_oe_n;

  property p_idle_high;
    @(posedge clock_in) disable iff (!rst_n_in)
      !s_r.tx_busy |-> txd_out;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("line not high while transmitter idle");

  property p_start_low;
    @(posedge clock_in) disable iff (!rst_n_in)
      $rose(s_r.tx_busy) |-> !txd_out;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("frame did not open with a low start bit");

  property p_pin_release;
    @(posedge clock_in) disable iff (!rst_n_in)
      !s_r.tx_en |-> txd_oe_n_out;
  endproperty
  a_pin_release: assert property (p_pin_release)
    else $error("disabled transmitter still drives the pin");

  property p_disable_wait;
    @(posedge clock_in) disable iff (!rst_n_in)
      s_r.tx_en && (s_r.tb_full || s_r.dr_full ||
      (s_r.tx_busy && !tx_finish)) |=> s_r.tx_en;
  endproperty
  a_disable_wait: assert property (p_disable_wait)
    else $error("transmitter disabled with data pending");

  property p_rx_flush;
    @(posedge clock_in) disable iff (!rst_n_in)
      !s_r.ctrl[usart_pkg::CTRL_RXEN] |=> s_r.rb_cnt == 2'h0 && !s_r.rx_busy;
  endproperty
  a_rx_flush: assert property (p_rx_flush)
    else $error("disabled receiver kept buffered data");

  property p_push;
    @(posedge clock_in) disable iff (!rst_n_in)
      push && !pop && s_r.rb_cnt != 2'h2 && s_r.ctrl[usart_pkg::CTRL_RXEN]
      |=> s_r.rb_cnt == $past(s_r.rb_cnt) + 2'h1;
  endproperty
  a_push: assert property (p_push)
    else $error("completed frame not stored in receive buffer");

  property p_overflow;
    @(posedge clock_in) disable iff (!rst_n_in)
      push && !pop && s_r.rb_cnt == 2'h2 && s_r.ctrl[usart_pkg::CTRL_RXEN]
      |=> s_r.rb_ov[1] && s_r.rb_cnt == 2'h2;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("lost frame not marked as overflow");

  property p_tx_done;
    @(posedge clock_in) disable iff (!rst_n_in)
      tx_finish && !s_r.dr_full && !s_r.tb_full |=> s_r.tx_done;
  endproperty
  a_tx_done: assert property (p_tx_done)
    else $error("transmit complete not flagged");

  property p_half_rate;
    @(posedge clock_in) disable iff (!rst_n_in)
      !sync_mode && s_r.baud == 16'h0080 && $stable(s_r.baud) && tick
      |=> !tick ##1 tick;
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("divisor 128 does not tick every second clock");
endmodule
`default_nettype wire

// ### tb/serial_node.sv
// remote serial node facing the transceiver: sends frames on the receive
// line and decodes frames from the transmit line
// assumes the default divisor, so one bit lasts 16 clocks
`timescale 1ns/1ps
`default_nettype none
module serial_node (
  // clock
  input wire logic clock_in,
  // serial lines
  input wire logic txd_in,
  output logic rxd_out,
  // frame format shared with the bench
  input wire logic [3:0] nbits_in,
  input wire logic [1:0] par_in,
  // decoded frame: stop, parity, data
  output logic got_out,
  output logic [10:0] word_out
);
  logic [10:0] w;

  initial rxd_out = 1'b1;

  task automatic put(input logic b);
    rxd_out <= b;
    repeat (16) @(posedge clock_in);
  endtask

  // data must already be cut to the character size
  task automatic send(input logic [8:0] d, input logic pe, input logic fe);
    put(1'b0);
    for (int i = 0; i < nbits_in; i++) put(d[i]);
    if (par_in[1]) put(^d ^ par_in[0] ^ pe);
    put(~fe);
    put(1'b1);
  endtask

  initial begin
    got_out = 1'b0;
    word_out = '0;
    forever begin
      @(negedge txd_in);
      repeat (8) @(posedge clock_in);
      if (txd_in === 1'b0) begin
        w = '0;
        for (int i = 0; i < nbits_in; i++) begin
          repeat (16) @(posedge clock_in);
          w[i] = txd_in;
        end
        if (par_in[1]) begin
          repeat (16) @(posedge clock_in);
          w[9] = txd_in;
        end
        repeat (16) @(posedge clock_in);
        w[10] = txd_in;
        word_out <= w;
        got_out <= 1'b1;
        @(posedge clock_in);
        got_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/usart_frame_baud_txrx_bench.sv
// self-checking bench: register access over axi4-lite, frames checked
// through the remote node model
// assumes the default divisor and normal speed for all frame tests
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))
module usart_frame_baud_txrx_bench;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  wire awready, wready, bvalid, arready, rvalid, rxd, txd, txd_oe_n, got;
  wire tclk, tclk_oe_n;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [10:0] word;
  logic [3:0] nbits = 4'h8;
  logic [1:0] par = 2'h0;
  logic [2:0] csz = 3'h3;
  logic [10:0] expq[$];
  logic [31:0] rd_d;
  logic [1:0] rd_r;
  logic [8:0] d;
  int n_fail = 0;
  int cmp_count = 0;

  usart_frame_baud_txrx u_usart_frame_baud_txrx (
    .clock_in(clock_in), .rst_n_in(rst_n_in),
    .axi_awvalid_in(awvalid), .axi_awready_out(awready),
    .axi_awaddr_in(awaddr), .axi_wvalid_in(wvalid),
    .axi_wready_out(wready), .axi_wdata_in(wdata), .axi_wstrb_in(wstrb),
    .axi_bvalid_out(bvalid), .axi_bready_in(bready),
    .axi_bresp_out(bresp), .axi_arvalid_in(arvalid),
    .axi_arready_out(arready), .axi_araddr_in(araddr),
    .axi_rvalid_out(rvalid), .axi_rready_in(rready),
    .axi_rdata_out(rdata), .axi_rresp_out(rresp),
    .rxd_in(rxd), .txd_out(txd), .txd_oe_n_out(txd_oe_n),
    .transfer_clock_pin_in(1'b0), .transfer_clock_pin_out(tclk),
    .transfer_clock_pin_oe_n_out(tclk_oe_n));

  serial_node u_serial_node (
    .clock_in(clock_in), .txd_in(txd), .rxd_out(rxd),
    .nbits_in(nbits), .par_in(par), .got_out(got), .word_out(word));

  initial forever #10 clock_in = ~clock_in;

  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_in);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_d = rdata;
    rd_r = rresp;
  endtask

  task automatic wait_st(input int b);
    do rd(usart_pkg::STATUS_OFS); while (rd_d[b] !== 1'b1);
  endtask

  // send one character; bits above the size are left set on purpose
  task automatic tx(input logic [8:0] v);
    logic [8:0] m;
    m = v & ((9'h1 << nbits) - 9'h1);
    wait_st(usart_pkg::STAT_DRE);
    expq.push_back({1'b1, par[1] & (^m ^ par[0]), m});
    if (csz == usart_pkg::CS_9H) wr(usart_pkg::TX_HIGH_OFS, {31'h0, v[8]});
    wr(usart_pkg::TX_LOW_OFS, {23'h0, v});
    if (csz == usart_pkg::CS_9L) wr(usart_pkg::TX_HIGH_OFS, {31'h0, v[8]});
  endtask

  // read one frame in the non-advancing order first
  task automatic rxchk(input logic [8:0] v, input logic [7:0] hi);
    wait_st(usart_pkg::STAT_RXC);
    for (int k = 0; k < 2; k++) begin
      if ((k == 0) == (csz == usart_pkg::CS_9L)) begin
        rd(usart_pkg::RX_LOW_OFS);
        `CHK(rd_d, v[7:0]);
      end else begin
        rd(usart_pkg::RX_HIGH_OFS);
        `CHK(rd_d, hi | {7'h0, v[8]});
      end
    end
  endtask

  task automatic tx_idle;
    while (expq.size() > 0) @(posedge clock_in);
    repeat (32) @(posedge clock_in);
  endtask

  always @(posedge clock_in) begin
    if (got === 1'b1) begin
      `CHK(word, (expq.size() > 0) ? expq.pop_front() : 11'hxxx);
    end
  end

  initial begin
    repeat (80000) @(posedge clock_in);
    n_fail++;
    test_done();
  end

  initial begin
    logic [7:0] ra[4];
    logic [31:0] rv[4];
    logic pe;
    logic fe;
    ra = '{usart_pkg::CTRL_OFS, usart_pkg::FRAME_OFS, usart_pkg::BAUD_OFS,
           usart_pkg::STATUS_OFS};
    rv = '{usart_pkg::CTRL_RST, usart_pkg::FRAME_RST, usart_pkg::BAUD_RST,
           32'h20};
    void'($urandom(32'h8d9c5f88));
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHK(rd_d, rv[i]);
    end
    rd(8'h40);
    `CHK(rd_r, usart_pkg::RESP_SLVERR);
    `CHK(rd_d, 32'h0);
    $display("reset values done");
    wr(usart_pkg::CTRL_OFS, 32'hc0);
    for (int k = 0; k < 10; k++) begin
      nbits = (k < 8) ? 4'(5 + k % 4) : 4'h9;
      csz = (k == 9) ? usart_pkg::CS_9H :
        (k == 8) ? usart_pkg::CS_9L : 3'(nbits - 4'h5);
      par = (k < 4) ? 2'h0 : 2'(2 + k % 2);
      wr(usart_pkg::FRAME_OFS, {26'h0, par, 1'(k % 3 == 1), csz});
      tx(9'($urandom));
      tx(9'($urandom));
      rd(usart_pkg::STATUS_OFS);
      `CHK(rd_d[6], 1'b0);
      tx_idle();
      rd(usart_pkg::STATUS_OFS);
      `CHK(rd_d[6:5], 2'h3);
      wr(usart_pkg::STATUS_OFS, 32'h40);
      d = 9'($urandom) & ((9'h1 << nbits) - 9'h1);
      pe = (k == 5);
      fe = (k == 6);
      u_serial_node.send(d, pe, fe);
      rxchk(d, {5'h10, fe, pe, 1'b0});
    end
    $display("frame formats done");
    wr(usart_pkg::FRAME_OFS, 32'h03);
    nbits = 4'h8;
    csz = 3'h3;
    par = 2'h0;
    for (int i = 1; i < 4; i++) u_serial_node.send(9'(8'h11 * i), 1'b0, 1'b0);
    rxchk(9'h11, 8'h80);
    rxchk(9'h22, 8'hc0);
    rd(usart_pkg::STATUS_OFS);
    `CHK(rd_d[7], 1'b0);
    $display("overflow done");
    u_serial_node.send(9'h5a, 1'b0, 1'b0);
    wr(usart_pkg::CTRL_OFS, 32'h40);
    rd(usart_pkg::STATUS_OFS);
    `CHK(rd_d[7], 1'b0);
    tx(9'h0a5);
    wr(usart_pkg::CTRL_OFS, 32'h00);
    `CHK(txd_oe_n, 1'b0);
    tx_idle();
    `CHK(txd_oe_n, 1'b1);
    $display("disable done");
    wr(usart_pkg::BAUD_OFS, 32'h80);
    rd(usart_pkg::BAUD_OFS);
    `CHK(rd_d, 32'h80);
    wr(usart_pkg::FRAME_OFS, 32'h43);
    wr(usart_pkg::CTRL_OFS, 32'h04);
    // let the accumulator settle into the synchronous step
    repeat (130) @(posedge clock_in);
    `CHK(tclk_oe_n, 1'b0);
    d[0] = tclk;
    repeat (2) @(posedge clock_in);
    `CHK(tclk, !d[0]);
    $display("transfer clock done");
    test_done();
  end
endmodule
`default_nettype wire
